// file: hw/ord_pkg.sv
// constants for the on-chip ram and its address decode
package ord_pkg;
   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int RAM_BYTES = 512;
   localparam int DATA_W = 16;
   localparam int RAM_WORDS = RAM_BYTES / 2;
   localparam int IDX_W = $clog2(RAM_WORDS);
   localparam int ADDR_W = 24;
   // ---------------------------------------------------------------
   // address windows
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] WIN_SHORT_LO = 24'h0ffd10;
   localparam logic [ADDR_W-1:0] WIN_SHORT_HI = 24'h0fff0f;
   localparam logic [ADDR_W-1:0] WIN_LONG_LO = 24'hfffd10;
   localparam logic [ADDR_W-1:0] WIN_LONG_HI = 24'hffff0f;
   localparam int SHORT_ADDR_W = 20;
   // mode pins: code 0..3 stands for operating mode 1..4
   localparam logic [1:0] MODE_FIRST_LONG = 2'h2;
   // ---------------------------------------------------------------
   // register map: byte address is four times the register index
   // ---------------------------------------------------------------
   localparam logic [15:0] SYSCTL_IDX = 16'hfff2;
   localparam logic [15:0] STATUS_IDX = 16'hfff3;
   localparam int REG_ADDR_W = 18;
   localparam logic [REG_ADDR_W-1:0] SYSCTL_ADDR = {SYSCTL_IDX, 2'h0};
   localparam logic [REG_ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
   localparam logic [7:0] SYSCTL_RESET = 8'h0b;
   localparam int RAM_EN_BIT = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ONE = 3'b010,
      ST_TWO = 3'b100
   } ord_state_t;
endpackage

// file: hw/ord_ram_array.sv
// 16-bit wide static ram array with two byte lanes
`timescale 1ns/1ps
module ord_ram_array #(
   parameter int WORDS = 256,
   parameter int IW = 8
) (
   input wire logic clk_in,
   input wire logic we_hi_in,
   input wire logic we_lo_in,
   input wire logic [IW-1:0] idx_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out
);
   logic [15:0] mem [WORDS];

   always_ff @(posedge clk_in) begin
      if (we_hi_in) begin
         mem[idx_in][15:8] <= wdata_in[15:8];
      end
      if (we_lo_in) begin
         mem[idx_in][7:0] <= wdata_in[7:0];
      end
   end

   assign rdata_out = mem[idx_in];
endmodule

// file: hw/ord_onchip_ram.sv
// on-chip ram, window decode and system control register
`timescale 1ns/1ps
module ord_onchip_ram
   import ord_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // processor side
   input wire logic cpu_req_in,
   input wire logic [ADDR_W-1:0] cpu_addr_in,
   input wire logic cpu_write_in,
   input wire logic cpu_word_in,
   input wire logic [DATA_W-1:0] cpu_wdata_in,
   output logic cpu_ready_out,
   output logic cpu_done_out,
   output logic [DATA_W-1:0] cpu_rdata_out,
   output logic ext_req_out,
   output logic [ADDR_W-1:0] ext_addr_out,
   // pins
   input wire logic [1:0] mode_in,
   input wire logic standby_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic [1:0] hresp_out
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] mode_meta_reg, mode_reg;
   logic stby_meta_reg, stby_reg;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mode_meta_reg <= 2'h0;
         mode_reg <= 2'h0;
         stby_meta_reg <= 1'b0;
         stby_reg <= 1'b0;
      end else begin
         mode_meta_reg <= mode_in;
         mode_reg <= mode_meta_reg;
         stby_meta_reg <= standby_in;
         stby_reg <= stby_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // system control register over ahb-lite
   // ---------------------------------------------------------------
   logic [7:0] sysctl_reg;
   logic wr_pend_reg;
   logic [REG_ADDR_W-1:0] wr_addr_reg;
   logic bus_take;
   logic ram_en;
   ord_state_t state_reg;

   assign bus_take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
   assign ram_en = sysctl_reg[RAM_EN_BIT];

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= bus_take && hwrite_in;
         wr_addr_reg <= haddr_in[REG_ADDR_W-1:0];
      end
   end

   // only the reset and a bus write touch this register
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sysctl_reg <= SYSCTL_RESET;
      end else if (wr_pend_reg && wr_addr_reg == SYSCTL_ADDR) begin
         sysctl_reg <= hwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hrdata_out <= 32'h0;
         hreadyout_out <= 1'b0;
         hresp_out <= HRESP_OKAY;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= HRESP_OKAY;
         if (bus_take && !hwrite_in && haddr_in[REG_ADDR_W-1:0] == SYSCTL_ADDR) begin
            hrdata_out <= {24'h0, sysctl_reg};
         end else if (bus_take && !hwrite_in && haddr_in[REG_ADDR_W-1:0] == STATUS_ADDR) begin
            hrdata_out <= {28'h0, stby_reg, mode_reg, state_reg == ST_IDLE};
         end else begin
            hrdata_out <= 32'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // window decode
   // ---------------------------------------------------------------
   logic long_mode, hit_short, hit_long, win_hit, acc_ok, acc_int;
   logic [ADDR_W-1:0] short_addr, offset;

   assign long_mode = mode_reg >= MODE_FIRST_LONG;
   assign short_addr = {{(ADDR_W-SHORT_ADDR_W){1'b0}}, cpu_addr_in[SHORT_ADDR_W-1:0]};
   assign hit_short = short_addr >= WIN_SHORT_LO && short_addr <= WIN_SHORT_HI;
   assign hit_long = cpu_addr_in >= WIN_LONG_LO && cpu_addr_in <= WIN_LONG_HI;
   assign win_hit = long_mode ? hit_long : hit_short;
   assign acc_ok = cpu_req_in && (state_reg == ST_IDLE) && !stby_reg;
   assign acc_int = acc_ok && win_hit && ram_en;
   assign offset = long_mode ? cpu_addr_in - WIN_LONG_LO : short_addr - WIN_SHORT_LO;

   // ---------------------------------------------------------------
   // three-state access sequencer: idle, then two access states
   // ---------------------------------------------------------------
   logic [IDX_W-1:0] idx_reg;
   logic odd_reg, write_reg, word_reg;
   logic [DATA_W-1:0] wdata_reg, arr_q;
   logic we_hi, we_lo;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (acc_int) begin
                  state_reg <= ST_ONE;
               end
            end
            ST_ONE: state_reg <= ST_TWO;
            ST_TWO: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         idx_reg <= '0;
         odd_reg <= 1'b0;
         write_reg <= 1'b0;
         word_reg <= 1'b0;
         wdata_reg <= '0;
      end else if (acc_int) begin
         idx_reg <= offset[IDX_W:1];
         odd_reg <= offset[0];
         write_reg <= cpu_write_in;
         word_reg <= cpu_word_in;
         wdata_reg <= cpu_wdata_in;
      end
   end

   // byte lanes: even address is the upper lane; bytes ride on the upper lines
   assign we_hi = (state_reg == ST_ONE) && write_reg && (word_reg || !odd_reg);
   assign we_lo = (state_reg == ST_ONE) && write_reg && (word_reg || odd_reg);

   ord_ram_array #(
      .WORDS(RAM_WORDS),
      .IW(IDX_W)
   ) u_array (
      .clk_in(clk_in),
      .we_hi_in(we_hi),
      .we_lo_in(we_lo),
      .idx_in(idx_reg),
      .wdata_in(word_reg ? wdata_reg : {wdata_reg[15:8], wdata_reg[15:8]}),
      .rdata_out(arr_q)
   );

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cpu_done_out <= 1'b0;
         cpu_rdata_out <= '0;
      end else begin
         cpu_done_out <= state_reg == ST_ONE;
         if (state_reg == ST_ONE && !write_reg) begin
            if (word_reg) begin
               cpu_rdata_out <= arr_q;
            end else begin
               cpu_rdata_out <= {odd_reg ? arr_q[7:0] : arr_q[15:8], 8'h0};
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cpu_ready_out <= 1'b0;
         ext_req_out <= 1'b0;
         ext_addr_out <= '0;
      end else begin
         cpu_ready_out <= (state_reg == ST_TWO) || (state_reg == ST_IDLE && !acc_int);
         ext_req_out <= acc_ok && !(win_hit && ram_en);
         if (acc_ok && !(win_hit && ram_en)) begin
            ext_addr_out <= cpu_addr_in;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   win_size_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      acc_int |-> (32'(offset) < RAM_BYTES) && (WIN_SHORT_HI - WIN_SHORT_LO + 1 == RAM_BYTES))
      else $error("ram index outside the array");
   short_window_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (acc_ok && ram_en && !long_mode && cpu_addr_in[SHORT_ADDR_W-1:0] == WIN_SHORT_LO[SHORT_ADDR_W-1:0])
      |=> state_reg == ST_ONE && !ext_req_out)
      else $error("short window start not routed to the ram");
   long_window_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (acc_ok && ram_en && long_mode && cpu_addr_in == WIN_LONG_HI) |=> state_reg == ST_ONE ##1 cpu_done_out)
      else $error("long window end not routed to the ram");
   disabled_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (acc_ok && win_hit && !ram_en) |=> ext_req_out && ext_addr_out == $past(cpu_addr_in) && state_reg == ST_IDLE)
      else $error("disabled window access not sent outside");
   reset_enable_a: assert property (@(posedge clk_in)
      $fell(sys_rst_in) |-> ram_en && sysctl_reg == SYSCTL_RESET)
      else $error("enable bit not set after reset");
   standby_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !wr_pend_reg |=> $stable(sysctl_reg))
      else $error("enable bit changed without a bus write");
   byte_lanes_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state_reg == ST_ONE && !word_reg && !write_reg) |=> cpu_done_out && cpu_rdata_out[7:0] == 8'h0 ##1 !cpu_done_out)
      else $error("byte read not on upper lines in two states");
   word_two_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (acc_int && cpu_word_in) |=> !cpu_done_out ##1 cpu_done_out ##1 state_reg == ST_IDLE)
      else $error("word access did not finish in two states");
   byte_lane_one_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state_reg == ST_ONE && write_reg && !word_reg) |-> (we_hi ^ we_lo))
      else $error("byte write did not hit exactly one lane");
   word_lane_both_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state_reg == ST_ONE && write_reg && word_reg) |-> (we_hi && we_lo))
      else $error("word write did not hit both lanes");
   busy_two_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      acc_int |=> !cpu_ready_out ##1 !cpu_ready_out ##1 cpu_ready_out)
      else $error("sequencer busy for other than two states");
   sysctl_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (wr_pend_reg && wr_addr_reg == SYSCTL_ADDR) |=> 32'(sysctl_reg) == ($past(hwdata_in) & 32'h000000ff))
      else $error("system control write did not land");
endmodule

// file: tb/ord_cpu_model.sv
// processor core model driving the internal ram bus
`timescale 1ns/1ps
module ord_cpu_model
   import ord_pkg::*;
(
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic done_in,
   input wire logic ext_in,
   output logic req_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic write_out,
   output logic word_out,
   output logic [DATA_W-1:0] wdata_out
);
   initial begin
      req_out = 1'b0;
      addr_out = '0;
      write_out = 1'b0;
      word_out = 1'b0;
      wdata_out = '0;
   end
   // request held until an edge sees the sequencer idle
   task automatic access(input logic [ADDR_W-1:0] a, input logic w, input logic wd,
      input logic [DATA_W-1:0] d, output int lat, output logic ext);
      @(posedge clk_in);
      req_out <= 1'b1;
      addr_out <= a;
      write_out <= w;
      word_out <= wd;
      wdata_out <= d;
      do @(posedge clk_in); while (ready_in !== 1'b1);
      // released lines carry inverted values, not the last ones
      req_out <= 1'b0;
      addr_out <= ~a;
      write_out <= ~w;
      word_out <= ~wd;
      wdata_out <= ~d;
      // the first state starts at the taking edge
      #1;
      lat = 1;
      while (lat < 8 && done_in !== 1'b1 && ext_in !== 1'b1) begin
         @(posedge clk_in);
         #1;
         lat++;
      end
      ext = ext_in;
   endtask
endmodule

// file: tb/onchip_ram_decode_bench.sv
// self-checking bench for the on-chip ram and its decode
`timescale 1ns/1ps
module onchip_ram_decode_bench
   import ord_pkg::*;
;
   localparam logic [31:0] SC = {14'h0, SYSCTL_ADDR};
   localparam logic [31:0] STS = {14'h0, STATUS_ADDR};
   logic clk_in = 1'b0, sys_rst_in = 1'b1, standby = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] mode = 2'h0, htrans = 2'h0, hresp;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic ready, done, ext_req, hready, req, wr, wd;
   logic [15:0] rdata, wdat;
   logic [23:0] ext_addr, addr;
   int errors = 0, checks = 0;
   always #5 clk_in = ~clk_in;
   ord_onchip_ram dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cpu_req_in(req), .cpu_addr_in(addr),
      .cpu_write_in(wr), .cpu_word_in(wd), .cpu_wdata_in(wdat), .cpu_ready_out(ready), .cpu_done_out(done),
      .cpu_rdata_out(rdata), .ext_req_out(ext_req), .ext_addr_out(ext_addr), .mode_in(mode),
      .standby_in(standby), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp));
   ord_cpu_model cpu (.clk_in(clk_in), .ready_in(ready), .done_in(done), .ext_in(ext_req), .req_out(req),
      .addr_out(addr), .write_out(wr), .word_out(wd), .wdata_out(wdat));
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ahb(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
      @(posedge clk_in);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hready !== 1'b1);
      r = hrdata;
      chk("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
   endtask
   task automatic go(string nm, logic [23:0] a, logic w, logic b, logic [15:0] d, logic x, logic [15:0] e);
      int lat;
      logic ext;
      cpu.access(a, w, b, d, lat, ext);
      chk({nm, " ext"}, {31'h0, ext}, {31'h0, x});
      chk({nm, " lat"}, lat, x ? 32'h1 : 32'h2);
      if (x) chk({nm, " addr"}, {8'h0, ext_addr}, {8'h0, a});
      else if (!w) chk({nm, " data"}, {16'h0, rdata}, {16'h0, e});
   endtask
   task automatic rst(logic [1:0] m);
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      mode <= m;
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
   task automatic t_short();
      rst(2'h0);
      go("w lo", WIN_SHORT_LO, 1, 1, 16'h1234, 0, 0);
      go("b odd", WIN_SHORT_LO + 24'h1, 1, 0, 16'hab00, 0, 0);
      go("r lo", WIN_SHORT_LO, 0, 1, 0, 0, 16'h12ab);
      go("rb odd", WIN_SHORT_LO + 24'h1, 0, 0, 0, 0, 16'hab00);
      go("b hi", WIN_SHORT_HI, 1, 0, 16'h5a00, 0, 0);
      go("rb hi", WIN_SHORT_HI, 0, 0, 0, 0, 16'h5a00);
      go("above", WIN_SHORT_HI + 24'h1, 0, 1, 0, 1, 0);
      go("below", WIN_SHORT_LO - 24'h1, 0, 1, 0, 1, 0);
      $display("test short window done");
   endtask
   task automatic t_long();
      logic [31:0] r;
      rst(MODE_FIRST_LONG);
      go("w long", WIN_LONG_LO, 1, 1, 16'hc3e1, 0, 0);
      go("b long hi", WIN_LONG_HI, 1, 0, 16'h9600, 0, 0);
      go("rb long hi", WIN_LONG_HI, 0, 0, 0, 0, 16'h9600);
      go("long above", WIN_LONG_HI + 24'h1, 0, 1, 0, 1, 0);
      go("short in long", WIN_SHORT_LO, 0, 1, 0, 1, 0);
      rst(2'h3);
      ahb(0, STS, 0, r);
      chk("status mode4", r, 32'h00000007);
      go("mode4", WIN_LONG_LO, 0, 1, 0, 0, 16'hc3e1);
      rst(2'h1);
      go("mode2", WIN_SHORT_LO, 0, 1, 0, 0, 16'hc3e1);
      $display("test long window done");
   endtask
   task automatic t_enable();
      logic [31:0] r;
      ahb(0, SC, 0, r);
      chk("sysctl reset", r, {24'h0, SYSCTL_RESET});
      ahb(1, 32'h100, 32'hff, r);
      ahb(0, 32'h100, 0, r);
      chk("unmapped", r, 32'h0);
      ahb(1, SC, 32'h0a, r);
      go("off", WIN_SHORT_LO, 0, 1, 0, 1, 0);
      @(posedge clk_in);
      standby <= 1'b1;
      repeat (4) @(posedge clk_in);
      ahb(0, STS, 0, r);
      chk("status standby", r, 32'h0000000b);
      standby <= 1'b0;
      repeat (3) @(posedge clk_in);
      ahb(0, SC, 0, r);
      chk("standby keep", r, 32'h0a);
      rst(2'h1);
      ahb(0, SC, 0, r);
      chk("reset set", r, {24'h0, SYSCTL_RESET});
      go("on w", WIN_SHORT_LO, 1, 1, 16'h0f0f, 0, 0);
      go("on r", WIN_SHORT_LO, 0, 1, 0, 0, 16'h0f0f);
      $display("test enable bit done");
   endtask
   initial begin
      t_short();
      t_long();
      t_enable();
      final_report();
   end
   initial begin
      #100us;
      errors++;
      final_report();
   end
endmodule
